// file: rtl/adcsp_cfg.svh
// Purpose: constants for the converter serial port and power control
// Assumes: included by the design file only
// Notes: edge numbers count from 1 after the chip-select fall
`ifndef ADCSP_CFG_SVH
`define ADCSP_CFG_SVH
`define ADCSP_FRAME_EDGES 5'd16
`define ADCSP_TRACK_EDGE 5'd14
`define ADCSP_CTRL_EDGE 5'd15
`define ADCSP_AUX_EDGE 5'd11
`define ADCSP_SEL_CTRL 3'h0
`define ADCSP_SEL_RANGE_A 3'h1
`define ADCSP_SEL_RANGE_B 3'h2
`define ADCSP_SEL_SEQ 3'h3
`define ADCSP_CTRL_RESET 12'h000
`define ADCSP_AUX_RESET 7'h00
`define ADCSP_CHAN_HI 9
`define ADCSP_CHAN_LO 7
`define ADCSP_PMH_BIT 5
`define ADCSP_PML_BIT 4
`define ADCSP_REF_BIT 2
`define ADCSP_WEAK_BIT 1
`define ADCSP_PM_NORMAL 2'h0
`define ADCSP_PM_AUTOSTBY 2'h1
`define ADCSP_PM_AUTOSHDN 2'h2
`define ADCSP_PM_FULL 2'h3
`define ADCSP_CLK_NS 100
`define ADCSP_PWRUP_NS 700
`define ADCSP_PWRUP_CYC ((`ADCSP_PWRUP_NS + `ADCSP_CLK_NS - 1) / `ADCSP_CLK_NS)
`define ADCSP_FIFO_DEPTH 8
`define ADCSP_FIFO_WIDTH 16
`endif

// file: rtl/adcsp_pkg.sv
// Purpose: types shared by the serial port design and its bench
// Assumes: nothing
// Notes: result word is the sixteen bits sent out in a frame
package adcsp_pkg;
   // Output frame word, sent msb first
   typedef struct packed {
      logic [2:0] chan;
      logic sign;
      logic [11:0] mag;
   } adcsp_result_s;
   // Register contents seen from outside
   typedef struct packed {
      logic [6:0] seq;
      logic [6:0] range_b;
      logic [6:0] range_a;
      logic [11:0] ctrl;
   } adcsp_regs_s;
   // Power and track-and-hold status
   typedef struct packed {
      logic standby;
      logic shutdown;
      logic powering_up;
      logic hold;
      logic ref_on;
   } adcsp_power_s;
   typedef enum logic [1:0] {
      ADCSP_IDLE = 2'b00,
      ADCSP_FRAME = 2'b01,
      ADCSP_DONE = 2'b10
   } adcsp_state_e;
endpackage

// file: rtl/adcsp_core.sv
// Purpose: serial frame, register writes and power modes of the converter
// Assumes: serial clock idles high when chip select falls
// Notes: results arrive from the analog side through a small FIFO
// Function
// RULE1 - Autostandby powers down part of the core, reference stays on.
// RULE2 - Host sets reference bit when using autostandby.
// RULE3 - Enter standby on 15th rising edge after selecting autostandby.
// RULE4 - Standby keeps registers, lasts until chip select rises, then powers up.
// RULE5 - Chip select rise ending standby returns track-and-hold to tracking.
// RULE6 - Host waits 700 ns after wake before next chip select fall.
// RULE7 - After each conversion in autostandby, standby again on 15th rise.
// RULE8 - Serial clock is conversion clock and shift clock.
// RULE9 - Chip select fall: hold, sample, drive output line.
// RULE10 - Conversion takes 16 serial clocks; host supplies all of them.
// RULE11 - Track on 14th rising edge, release output on 16th falling edge.
// RULE12 - Early chip select rise aborts and floats output.
// RULE13 - Input sampled on falling edges; first three bits select register. Code takes the first bit as write bit, the next three as select.
// RULE14 - Control register loads on 15th rising edge.
// RULE15 - Sequence and range registers load on 11th falling edge.
// RULE16 - Output: three channel bits, sign bit, 12-bit magnitude.
// RULE17 - Weak-drive bit parks output at next frame's first channel bit.
// RULE18 - Write happens only when frame's write bit is set.
// RULE19 - Power bits: 00 normal, 11 full shutdown, 10 autoshutdown.
// RULE20 - Chip select high, weak clear: output floats, clock ignored.
// RULE21 - Channel bits name the conversion whose result follows.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Result FIFO between analog side and serial port
module adcsp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Handshake terms
   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers wrap because depth is a power of two
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
      end
   end

   // Fill level
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
         count <= count - (AW+1)'(1);
      end
   end
endmodule // adcsp_fifo

////////////////////////////////////////////////////////////////////////////////
// Serial port and power control
`include "adcsp_cfg.svh"
module adcsp_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial pins
   input wire logic cs_b,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic dout_oe_b,
   output logic dout_weak,
   // Analog side
   input wire logic res_valid,
   output logic res_ready,
   input wire adcsp_pkg::adcsp_result_s res_word,
   output logic sample_pulse,
   output logic [2:0] sample_chan,
   // Status
   output adcsp_pkg::adcsp_regs_s regs,
   output adcsp_pkg::adcsp_power_s power
);
   import adcsp_pkg::*;

   // Edge number test, used for every edge-timed event
   function automatic logic nth(input logic [4:0] cnt, input logic [4:0] n);
      return (cnt + 5'd1) == n;
   endfunction

   logic cs_s1, cs_s2, cs_s3;
   logic sclk_s1, sclk_s2, sclk_s3;
   logic din_s1, din_s2;
   logic cs_fall, cs_rise, sclk_fall, sclk_rise;
   adcsp_state_e state, next_state;
   logic [4:0] fall_cnt, rise_cnt;
   logic f_ev, r_ev, r15, load_ctrl, f11, weak_sel;
   logic [15:0] shreg, tx_sr;
   logic [11:0] ctrl, ctrl_data;
   logic [10:0] aux_v;
   logic [6:0] range_a, range_b, seq;
   logic [1:0] pm_eff;
   logic standby, autoshdn, full_shdn, hold;
   logic [3:0] pwrup_cnt;
   logic fifo_valid, fifo_pop;
   logic [15:0] fifo_head;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; third stage only feeds edge detection
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         cs_s1 <= cs_b;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         din_s1 <= din;
         din_s2 <= din_s1;
      end
   end

   // Serial clock edges drive all shifting and conversion steps [RULE8]
   assign cs_fall = cs_s3 && !cs_s2;
   assign cs_rise = !cs_s3 && cs_s2;
   assign sclk_fall = sclk_s3 && !sclk_s2;
   assign sclk_rise = !sclk_s3 && sclk_s2;
   // Edges only count inside a frame with chip select low [RULE20]
   assign f_ev = (state == ADCSP_FRAME) && sclk_fall && !cs_rise;
   assign r_ev = (state == ADCSP_FRAME) && sclk_rise && !cs_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         ADCSP_IDLE: if (cs_fall) next_state = ADCSP_FRAME;
         ADCSP_FRAME: begin
            if (cs_rise) begin
               next_state = ADCSP_IDLE; // [RULE12]
            end else if (f_ev && nth(fall_cnt, `ADCSP_FRAME_EDGES)) begin
               next_state = ADCSP_DONE; // [RULE10]
            end
         end
         ADCSP_DONE: if (cs_rise) next_state = ADCSP_IDLE;
         default: next_state = ADCSP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= ADCSP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Edge counters, cleared at frame start
   always_ff @(posedge clk) begin
      if (!rst_b || cs_fall) begin
         fall_cnt <= 5'd0;
         rise_cnt <= 5'd0;
      end else begin
         if (f_ev) fall_cnt <= fall_cnt + 5'd1;
         if (r_ev) rise_cnt <= rise_cnt + 5'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input shift on falling edges, msb first [RULE13]
   always_ff @(posedge clk) begin
      if (!rst_b || cs_fall) begin
         shreg <= 16'h0000;
      end else if (f_ev) begin
         shreg <= {shreg[14:0], din_s2};
      end
   end

   // Eleven bits at the 11th fall: write, select, seven data bits
   assign aux_v = {shreg[9:0], din_s2};
   assign f11 = f_ev && nth(fall_cnt, `ADCSP_AUX_EDGE) && aux_v[10]; // [RULE18]
   // Last data bit is not yet clocked at the 15th rise, so the line is taken
   assign ctrl_data = {shreg[10:0], din_s2};
   assign r15 = r_ev && nth(rise_cnt, `ADCSP_CTRL_EDGE);
   assign load_ctrl = r15 && shreg[14] && (shreg[13:11] == `ADCSP_SEL_CTRL); // [RULE18]

   // Control register [RULE14]
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl <= `ADCSP_CTRL_RESET;
      end else if (load_ctrl) begin
         ctrl <= ctrl_data;
      end
   end

   // Sequence and range registers [RULE15]
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         range_a <= `ADCSP_AUX_RESET;
         range_b <= `ADCSP_AUX_RESET;
         seq <= `ADCSP_AUX_RESET;
      end else if (f11) begin
         if (aux_v[9:7] == `ADCSP_SEL_RANGE_A) range_a <= aux_v[6:0];
         if (aux_v[9:7] == `ADCSP_SEL_RANGE_B) range_b <= aux_v[6:0];
         if (aux_v[9:7] == `ADCSP_SEL_SEQ) seq <= aux_v[6:0];
      end
   end

   assign regs = '{seq: seq, range_b: range_b, range_a: range_a, ctrl: ctrl};
   assign weak_sel = ctrl[`ADCSP_WEAK_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Power mode as it stands after this frame's control write [RULE19]
   assign pm_eff = load_ctrl ? {ctrl_data[`ADCSP_PMH_BIT], ctrl_data[`ADCSP_PML_BIT]}
                             : {ctrl[`ADCSP_PMH_BIT], ctrl[`ADCSP_PML_BIT]};

   // Auto modes enter at the 15th rise of every frame, leave on chip select rise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         standby <= 1'b0;
         autoshdn <= 1'b0;
      end else if (cs_rise) begin
         standby <= 1'b0; // [RULE4]
         autoshdn <= 1'b0;
      end else if (r15) begin
         standby <= pm_eff == `ADCSP_PM_AUTOSTBY; // [RULE3] [RULE7]
         autoshdn <= pm_eff == `ADCSP_PM_AUTOSHDN;
      end
   end

   // Full shutdown follows the bits, so it only changes at a control write
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         full_shdn <= 1'b0;
      end else if (r15) begin
         full_shdn <= pm_eff == `ADCSP_PM_FULL;
      end
   end

   // Wake timer; the host must not start a conversion meanwhile [RULE6]
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pwrup_cnt <= 4'h0;
      end else if (cs_rise && standby) begin
         pwrup_cnt <= 4'(`ADCSP_PWRUP_CYC); // [RULE4]
      end else if (pwrup_cnt != 4'h0) begin
         pwrup_cnt <= pwrup_cnt - 4'h1;
      end
   end

   // Track-and-hold: hold at frame start and from the 15th rise of a power-down frame until chip select rises
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hold <= 1'b0;
      end else if (cs_rise) begin
         hold <= 1'b0; // [RULE5]
      end else if (cs_fall && state == ADCSP_IDLE) begin
         hold <= 1'b1; // [RULE9]
      end else if (r15 && pm_eff != `ADCSP_PM_NORMAL) begin
         hold <= 1'b1;
      end else if (r_ev && nth(rise_cnt, `ADCSP_TRACK_EDGE)) begin
         hold <= 1'b0; // [RULE11]
      end
   end

   // Reference follows its control bit in standby, always down when shut down [RULE1]
   assign power = '{standby: standby, shutdown: full_shdn || autoshdn,
                    powering_up: pwrup_cnt != 4'h0, hold: hold,
                    ref_on: ctrl[`ADCSP_REF_BIT] && !full_shdn && !autoshdn};

   ////////////////////////////////////////////////////////////////////////////
   // Sample request to the analog side at each conversion start
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sample_pulse <= 1'b0;
         sample_chan <= 3'h0;
      end else begin
         sample_pulse <= cs_fall && state == ADCSP_IDLE; // [RULE9]
         if (cs_fall) sample_chan <= ctrl[`ADCSP_CHAN_HI:`ADCSP_CHAN_LO];
      end
   end

   // Results queue up; a slow host stalls the analog side through res_ready
   assign fifo_pop = cs_fall && state == ADCSP_IDLE;
   adcsp_fifo #(
      .WIDTH(`ADCSP_FIFO_WIDTH),
      .DEPTH(`ADCSP_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(res_valid),
      .in_ready(res_ready),
      .in_data(res_word),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_head)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output shift: tagged word, one bit per falling edge [RULE16] [RULE21]
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tx_sr <= 16'h0000;
         dout <= 1'b0;
      end else if (fifo_pop) begin
         tx_sr <= {(fifo_valid ? fifo_head[14:0] : 15'h0000), 1'b0};
         dout <= fifo_valid && fifo_head[15];
      end else if (f_ev) begin
         tx_sr <= {tx_sr[14:0], 1'b0};
         dout <= tx_sr[15];
      end else if (state != ADCSP_FRAME) begin
         dout <= fifo_valid && fifo_head[15]; // [RULE17]
      end
   end

   // Drive control; weak parking replaces the float when selected
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dout_oe_b <= 1'b1;
         dout_weak <= 1'b0;
      end else if (fifo_pop) begin
         dout_oe_b <= 1'b0; // [RULE9]
         dout_weak <= 1'b0;
      end else if (cs_rise || (f_ev && nth(fall_cnt, `ADCSP_FRAME_EDGES))) begin
         dout_oe_b <= !weak_sel; // [RULE11] [RULE12]
         dout_weak <= weak_sel; // [RULE17]
      end else if (state != ADCSP_FRAME) begin
         dout_oe_b <= !weak_sel; // [RULE20]
         dout_weak <= weak_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_start;
      @(posedge clk) disable iff (!rst_b)
      fifo_pop |=> power.hold && !dout_oe_b && state == ADCSP_FRAME ##1 power.hold;
   endproperty
   a_start: assert property (p_start) else $error("frame start did not hold and drive"); // [RULE9]

   property p_track;
      @(posedge clk) disable iff (!rst_b)
      r_ev && nth(rise_cnt, `ADCSP_TRACK_EDGE) |=> !power.hold;
   endproperty
   a_track: assert property (p_track) else $error("no tracking after 14th rise"); // [RULE11]

   property p_end;
      @(posedge clk) disable iff (!rst_b)
      f_ev && nth(fall_cnt, `ADCSP_FRAME_EDGES) && !weak_sel |=> dout_oe_b && state == ADCSP_DONE;
   endproperty
   a_end: assert property (p_end) else $error("output not released at 16th fall"); // [RULE10]

   property p_abort;
      @(posedge clk) disable iff (!rst_b)
      cs_rise && state == ADCSP_FRAME && !weak_sel |=> dout_oe_b && state == ADCSP_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not float output"); // [RULE12]

   property p_ctrl;
      @(posedge clk) disable iff (!rst_b)
      load_ctrl |=> regs.ctrl == $past(ctrl_data);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control register not loaded"); // [RULE14]

   property p_seq;
      @(posedge clk) disable iff (!rst_b)
      f11 && aux_v[9:7] == `ADCSP_SEL_SEQ |=> regs.seq == $past(aux_v[6:0]);
   endproperty
   a_seq: assert property (p_seq) else $error("sequence register not loaded"); // [RULE15]

   property p_nowrite;
      @(posedge clk) disable iff (!rst_b)
      !load_ctrl |=> $stable(regs.ctrl);
   endproperty
   a_nowrite: assert property (p_nowrite) else $error("control changed without write"); // [RULE18]

   property p_stby;
      @(posedge clk) disable iff (!rst_b)
      r15 && pm_eff == `ADCSP_PM_AUTOSTBY |=> power.standby && power.hold && power.ref_on == ctrl[`ADCSP_REF_BIT];
   endproperty
   a_stby: assert property (p_stby) else $error("standby not entered at 15th rise"); // [RULE3]

   property p_wake;
      @(posedge clk) disable iff (!rst_b)
      power.standby && cs_rise |=> !power.standby && !power.hold && power.powering_up[*7] ##1 !power.powering_up;
   endproperty
   a_wake: assert property (p_wake) else $error("wake from standby wrong"); // [RULE5]

   property p_tag;
      @(posedge clk) disable iff (!rst_b)
      fifo_pop && fifo_valid |=> dout == $past(fifo_head[15]);
   endproperty
   a_tag: assert property (p_tag) else $error("first bit is not channel msb"); // [RULE21]

   property p_weak;
      @(posedge clk) disable iff (!rst_b)
      state == ADCSP_DONE && $past(state == ADCSP_DONE) && weak_sel |-> !dout_oe_b && dout_weak;
   endproperty
   a_weak: assert property (p_weak) else $error("weak parking missing"); // [RULE17]
endmodule // adcsp_core

// file: bench/adcsp_host.sv
// Purpose: host serial port model that frames conversions into the converter
// Assumes: serial clock of 8 clk a period, idle high between frames
// Notes: pins change just after clk edges; dout is read as the clock drops
`timescale 1ns/100ps
module adcsp_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic cs_b,
   output logic sclk,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe_b
);
   logic [15:0] got;
   logic oe_seen;
   // Deselected, clock parked high
   initial begin
      cs_b = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Frame of nfall falling edges; gap stretches the high phase to stall
   task automatic frame(input logic [15:0] w, input int nfall, input int gap);
      int i;
      got = 16'h0000;
      oe_seen = 1'b0;
      cs_b <= 1'b0;
      din <= w[15];
      for (i = 1; i <= nfall; i++) begin
         // First fall waits longer so bit 0 has left the syncs
         repeat ((i == 1 ? 6 : 4) + gap) @(posedge clk);
         got[16 - i] = dout_oe_b ? ~dout : dout; // Floating line reads as the inverse
         oe_seen = oe_seen | dout_oe_b;
         sclk <= 1'b0;
         repeat (2) @(posedge clk);
         // Mid-low change keeps din clear of both sampling edges
         if (i < 16) din <= w[15 - i];
         repeat (2) @(posedge clk);
         sclk <= 1'b1;
      end
      repeat (6) @(posedge clk);
   endtask
   // Deselect; released din shows the inverse level, not the last one
   // Eight clocks high covers the wake-up time before the next fall
   task automatic release_cs();
      cs_b <= 1'b1;
      din <= ~din;
      repeat (8) @(posedge clk);
   endtask
   // Clock edges while deselected, which the converter must ignore
   task automatic idle_clocks(input int n);
      repeat (n) begin
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         din <= ~din;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule // adcsp_host

// file: bench/adcsp_tb_top.sv
// Purpose: self-checking bench for the converter serial port
// Assumes: host model drives the pins, bench feeds the result FIFO
// Notes: a queue and register copies predict every frame
`timescale 1ns/100ps
module adcsp_tb_top;
   import adcsp_pkg::*;
   logic clk;
   logic rst_b = 1'b0;
   logic res_valid = 1'b0;
   adcsp_result_s res_word = 16'h0000;
   logic res_ready, sample_pulse, dout, dout_oe_b, dout_weak, cs_b, sclk, din;
   logic [2:0] sample_chan;
   adcsp_regs_s regs;
   adcsp_power_s power;
   int bad_count = 0;
   int checks_done = 0;
   int seed = 55235;
   int pulses = 0;
   logic [15:0] q[$];
   logic [11:0] m_ctrl = 12'h000;
   logic [6:0] m_ra = 7'h00;
   logic [6:0] m_rb = 7'h00;
   logic [6:0] m_seq = 7'h00;
   ////////////////////////////////////////////////////////////////////////////////
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   adcsp_core DUT (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe_b(dout_oe_b), .dout_weak(dout_weak), .res_valid(res_valid), .res_ready(res_ready),
      .res_word(res_word), .sample_pulse(sample_pulse), .sample_chan(sample_chan), .regs(regs),
      .power(power));
   adcsp_host u_host (.clk(clk), .cs_b(cs_b), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe_b(dout_oe_b));
   // Count conversion starts
   always @(posedge clk) begin
      if (sample_pulse === 1'b1) pulses <= pulses + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Offer one word; caller lowers valid once the burst ends
   task automatic push(input logic [15:0] w);
      int t;
      res_valid <= 1'b1;
      res_word <= w;
      t = 0;
      do @(posedge clk); while (res_ready !== 1'b1 && ++t < 50);
      check(res_ready, 1'b1);
      q.push_back(w);
   endtask
   // Control write word: chan, power bits, reference, weak drive
   function automatic logic [15:0] ctrl_w(input logic [2:0] ch, input logic [1:0] pm, input logic rf,
      input logic wk);
      return {4'h8, 2'b00, ch, 1'b0, pm, 1'b0, rf, wk, 1'b0};
   endfunction
   // One frame against the model; cs stays low afterwards
   task automatic run(input logic [15:0] w, input int nfall, input int gap);
      logic [15:0] exp;
      logic [2:0] ch0;
      logic [1:0] pm;
      int p0;
      exp = (q.size() > 0) ? q.pop_front() : 16'h0000;
      ch0 = m_ctrl[9:7];
      p0 = pulses;
      u_host.frame(w, nfall, gap);
      if (w[15] && nfall >= 11) begin
         case (w[14:12])
            3'h1: m_ra = w[11:5];
            3'h2: m_rb = w[11:5];
            3'h3: m_seq = w[11:5];
            default: ;
         endcase
      end
      if (w[15] && w[14:12] == 3'h0 && nfall >= 15) m_ctrl = w[11:0];
      check(regs, {m_seq, m_rb, m_ra, m_ctrl});
      check(33'(pulses - p0), 33'h1);
      check(sample_chan, ch0);
      if (nfall == 16) begin
         pm = m_ctrl[5:4];
         check(u_host.got, exp);
         check(u_host.oe_seen, 1'b0);
         check(power.standby, pm == 2'h1);
         check(power.shutdown, pm[1]);
         check(power.ref_on, m_ctrl[2] && !pm[1]);
         if (pm == 2'h0) check(power.hold, 1'b0);
         if (m_ctrl[1]) check({dout_oe_b, dout_weak, dout}, {2'b01, q.size() > 0 ? q[0][15] : 1'b0});
         else check(dout_oe_b, 1'b1);
      end
   endtask
   task automatic frm(input logic [15:0] w, input int gap);
      run(w, 16, gap);
      u_host.release_cs();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int k;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      check(regs, 33'h0);
      check({dout_oe_b, dout_weak, dout}, 3'b100);
      // Fill until refused, then drain with stalls, then read an empty FIFO
      for (k = 0; k < 8; k++) push(16'($random(seed)));
      res_valid <= 1'b0;
      @(posedge clk);
      check(res_ready, 1'b0);
      for (k = 0; k < 9; k++) frm({1'b0, 15'($random(seed))}, $random(seed) & 3);
      $display("test fifo done");
      // Each range and sequence register select
      for (k = 1; k < 4; k++) frm({1'b1, 3'(k), 12'($random(seed))}, 0);
      $display("test registers done");
      // Aborts before and after the auxiliary load edge
      run({1'b1, 3'h1, 12'($random(seed))}, 8, 0);
      u_host.release_cs();
      check(dout_oe_b, 1'b1);
      run({1'b1, 3'h2, 12'($random(seed))}, 13, 0);
      check(power.hold, 1'b1);
      u_host.release_cs();
      check({dout_oe_b, power.hold}, 2'b10);
      $display("test abort done");
      // Every power mode
      for (k = 0; k < 4; k++) frm(ctrl_w(3'($random(seed)), 2'(k), 1'b1, 1'b0), 0);
      frm(ctrl_w(3'h5, 2'h0, 1'b0, 1'b0), 0);
      $display("test modes done");
      // Clock edges while deselected leave port and FIFO alone
      push(16'($random(seed)));
      res_valid <= 1'b0;
      u_host.idle_clocks(3);
      check({dout_oe_b, regs}, {1'b1, m_seq, m_rb, m_ra, m_ctrl});
      frm(16'h0000, 0);
      $display("test idle done");
      // Autostandby entry, hold, wake and re-entry
      push(16'($random(seed)));
      res_valid <= 1'b0;
      run(ctrl_w(3'h2, 2'h1, 1'b1, 1'b0), 16, 0);
      check(power.ref_on, 1'b1);
      repeat (20) @(posedge clk);
      check({power.standby, regs}, {1'b1, m_seq, m_rb, m_ra, m_ctrl});
      u_host.release_cs();
      check({power.standby, power.hold, power.powering_up}, 3'b001);
      repeat (8) @(posedge clk);
      check(power.powering_up, 1'b0);
      push(16'($random(seed)));
      res_valid <= 1'b0;
      run(16'h0000, 16, 1);
      u_host.release_cs();
      frm(ctrl_w(3'h2, 2'h0, 1'b1, 1'b0), 0);
      $display("test standby done");
      // Weak parking at the next frame's first bit, also while deselected
      push(16'($random(seed)));
      push(16'($random(seed)) | 16'h8000);
      res_valid <= 1'b0;
      frm(ctrl_w(3'h1, 2'h0, 1'b0, 1'b1), 0);
      check({dout_oe_b, dout_weak, dout}, 3'b011);
      frm(ctrl_w(3'h1, 2'h0, 1'b0, 1'b0), 2);
      $display("test weak done");
      close_out();
   end
   // Watchdog
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      close_out();
   end
endmodule // adcsp_tb_top
